// ==== src/interval_timer_carry.sv ====
// interval timer: tick divider, carry flag with read-and-clear, CE reset sync, timer irq
`timescale 1ns/1ps
`include "interval_timer_map.svh"

// Overview of operation
// - outside clock stop and once armed by a read or CE reset, the carry flag is set on each rising edge of the tick picked by mode bits 1:0.
// - bit 0 of the carry judge register at 17H mirrors the carry flag exactly.
// - a read of the carry judge register returns the flag and then clears it.
// - clearing the judge bit clears the carry flip-flop itself, they never differ.
// - after power-on reset the flag stays 0 until the CPU has read it once or a CE reset forces it.
// - power-on reset clears the flag while CE reset, even in clock stop, forces it to 1.
// - after the CE pin rises, CE reset happens on the next carry-setting tick edge, or at once in clock stop.
// - writes to the carry judge register change nothing.
// - the mode register at 09H holds separate carry and interrupt interval selections.
// - all ticks come from dividing the system clock, so they scale with its rate.
// - the interrupt section raises a request at the interval selected for it.
// - the divider gives free-running independent 1 kHz, 200 Hz, 10 Hz and 4 Hz ticks.
// - select 00 gives 100 ms, 01 gives 250 ms, 10 gives 5 ms and 11 gives 1 ms.
// - on a select change the flag is set if the new tick is high and the old one was low, else holds.
// - a flag read coinciding with the CE sync tick wins and CE reset waits one tick.
module interval_timer_carry
  import interval_timer_pkg::*;
#(
  // period counts in clock cycles, shorten for simulation
  parameter int TICK_1KHZ_CYC  = `TMR_TICK_1KHZ_US * 1000 / `TMR_CLK_PERIOD_NS,
  parameter int TICK_200HZ_CYC = `TMR_TICK_200HZ_US * 1000 / `TMR_CLK_PERIOD_NS,
  parameter int TICK_10HZ_CYC  = `TMR_TICK_10HZ_US * 1000 / `TMR_CLK_PERIOD_NS,
  parameter int TICK_4HZ_CYC   = `TMR_TICK_4HZ_US * 1000 / `TMR_CLK_PERIOD_NS
)
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // register file port from cpu core
  input  wire logic [6:0] register_file_space_addr_in,
  input  wire logic       register_file_read_op_in,
  input  wire logic       register_file_write_op_in,
  input  wire logic [3:0] wr_data_in,
  output logic      [3:0] rd_data_out,
  // system control
  input  wire logic       ce_in,
  input  wire logic       clk_stop_in,
  // status and events
  output logic            tick_carry_flag_out,
  output logic            timer_irq_out,
  output logic            ce_reset_out
);

  localparam logic [3:0][27:0] PERIODS = {
    28'(TICK_4HZ_CYC), 28'(TICK_10HZ_CYC), 28'(TICK_200HZ_CYC), 28'(TICK_1KHZ_CYC)};

  carry_state_t st_ff;
  carry_state_t nxt_st;
  logic   [3:0] tick_lvl;
  logic         carry_lvl;
  logic         irq_lvl;
  logic         carry_rise;
  logic         irq_rise;
  logic         judge_rd;
  logic         mode_rd;
  logic         mode_wr;
  logic         ce_rise;
  logic         ce_fire;
  logic         tick_set;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  tick_divider #(
    .PERIODS (PERIODS)
  ) u_div (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .tick_lvl_out (tick_lvl)
  );

  // index 0 = 1 kHz, 1 = 200 Hz, 2 = 10 Hz, 3 = 4 Hz
  function automatic logic pick_tick(input logic [1:0] sel, input logic [3:0] lvl);
    case (sel)
      2'h0:    pick_tick = lvl[2];
      2'h1:    pick_tick = lvl[3];
      2'h2:    pick_tick = lvl[1];
      2'h3:    pick_tick = lvl[0];
      default: pick_tick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // decode and edges
  // ----------------------------------------------------------------
  assign carry_lvl  = pick_tick(st_ff.mode[`TMR_CARRY_SEL_LSB +: 2], tick_lvl);
  assign irq_lvl    = pick_tick(st_ff.mode[`TMR_IRQ_SEL_LSB +: 2], tick_lvl);
  // a select change from a low tick onto a high tick looks like an edge and sets the flag
  assign carry_rise = carry_lvl & ~st_ff.carry_lvl_prev;
  assign irq_rise   = irq_lvl & ~st_ff.irq_lvl_prev;
  assign judge_rd   = register_file_read_op_in &
                      (register_file_space_addr_in == `TMR_CARRY_JUDGE_ADDR);
  assign mode_rd    = register_file_read_op_in &
                      (register_file_space_addr_in == `TMR_INTERVAL_SELECT_ADDR);
  assign mode_wr    = register_file_write_op_in &
                      (register_file_space_addr_in == `TMR_INTERVAL_SELECT_ADDR);
  assign ce_rise    = ce_in & ~st_ff.ce_prev;
  // clock stop: the carry tick edge is masked, so CE reset is taken at once
  assign ce_fire    = (st_ff.ce_state == CE_WAIT_TICK) &
                      ((carry_rise & ~judge_rd & ~clk_stop_in) | clk_stop_in);
  assign tick_set   = carry_rise & st_ff.armed & ~clk_stop_in;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st                = st_ff;
    nxt_st.carry_lvl_prev = carry_lvl;
    nxt_st.irq_lvl_prev   = irq_lvl;
    nxt_st.ce_prev        = ce_in;
    nxt_st.irq            = irq_rise & ~clk_stop_in;
    nxt_st.ce_rst         = 1'b0;
    // carry judge is read-only, so only 09H takes writes
    if (mode_wr)
      nxt_st.mode = wr_data_in;
    if (judge_rd)
    begin
      nxt_st.rdata = 4'h0;
      nxt_st.rdata[`TMR_CARRY_FLAG_BIT] = st_ff.flag;
      nxt_st.flag  = 1'b0;
      nxt_st.armed = 1'b1;
    end
    else if (mode_rd)
      nxt_st.rdata = st_ff.mode;
    else if (register_file_read_op_in)
      nxt_st.rdata = 4'h0;
    // set wins over the read clear
    if (tick_set)
      nxt_st.flag = 1'b1;
    case (st_ff.ce_state)
      CE_IDLE:
        if (ce_rise)
          nxt_st.ce_state = CE_WAIT_TICK;
      CE_WAIT_TICK:
        if (ce_fire)
        begin
          nxt_st.ce_state = CE_IDLE;
          nxt_st.flag     = 1'b1;
          nxt_st.armed    = 1'b1;
          nxt_st.ce_rst   = 1'b1;
        end
      default:
        nxt_st.ce_state = CE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      st_ff      <= '0;
      st_ff.mode <= `TMR_INTERVAL_SELECT_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign rd_data_out         = st_ff.rdata;
  assign tick_carry_flag_out = st_ff.flag;
  assign timer_irq_out       = st_ff.irq;
  assign ce_reset_out        = st_ff.ce_rst;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  flag_tick_set_a: assert property (
    tick_set |=> tick_carry_flag_out)
    else $error("carry flag not set by tick");
  judge_mirror_a: assert property (
    judge_rd |=> rd_data_out == {3'h0, $past(tick_carry_flag_out)})
    else $error("judge read did not return flag");
  read_clear_a: assert property (
    judge_rd && !tick_set && !ce_fire |=> !tick_carry_flag_out)
    else $error("flag not cleared by read");
  unarmed_zero_a: assert property (
    !st_ff.armed |-> !tick_carry_flag_out)
    else $error("flag set before first read");
  write_ignored_a: assert property (
    register_file_write_op_in && !mode_wr && !tick_set && !ce_fire && !judge_rd
      |=> $stable(tick_carry_flag_out))
    else $error("write changed carry flag");
  mode_write_a: assert property (
    mode_wr |=> st_ff.mode == $past(wr_data_in))
    else $error("mode register not written");
  ce_force_a: assert property (
    ce_reset_out |-> tick_carry_flag_out && $past(st_ff.ce_state == CE_WAIT_TICK))
    else $error("ce reset did not force flag");
  ce_read_wins_a: assert property (
    st_ff.ce_state == CE_WAIT_TICK && carry_rise && judge_rd && !clk_stop_in
      |=> !ce_reset_out && st_ff.ce_state == CE_WAIT_TICK)
    else $error("ce reset not delayed by read");
  ce_sync_a: assert property (
    st_ff.ce_state == CE_WAIT_TICK && carry_rise && !judge_rd && !clk_stop_in
      |=> ce_reset_out ##1 !ce_reset_out)
    else $error("ce reset not on tick edge");
  irq_tick_a: assert property (
    irq_rise && !clk_stop_in |=> timer_irq_out ##1 !timer_irq_out)
    else $error("timer irq missing");
  // clock stop masks the tick set and the irq, so only ce reset and judge reads may still change the flag
  stop_ce_force_a: assert property (
    st_ff.ce_state == CE_WAIT_TICK && clk_stop_in |=> ce_reset_out && tick_carry_flag_out)
    else $error("ce reset in clock stop did not force flag");
  stop_irq_mute_a: assert property (
    clk_stop_in |=> !timer_irq_out)
    else $error("timer irq raised in clock stop");
  arm_on_read_a: assert property (
    judge_rd |=> st_ff.armed)
    else $error("judge read did not arm flag");

  cover_read_clear: cover property (judge_rd && tick_carry_flag_out ##1 !tick_carry_flag_out);
  cover_ce_reset: cover property (ce_rise ##[1:1000] ce_reset_out);
  cover_irq: cover property (timer_irq_out);
  cover_sel_change: cover property (mode_wr ##1 carry_rise);

endmodule // interval_timer_carry

// ==== src/interval_timer_map.svh ====
// register offsets, field positions, reset values and tick timing of the interval timer
`ifndef INTERVAL_TIMER_MAP_SVH
`define INTERVAL_TIMER_MAP_SVH

// ----------------------------------------------------------------
// register file offsets
// ----------------------------------------------------------------
`define TMR_INTERVAL_SELECT_ADDR 7'h09
`define TMR_CARRY_JUDGE_ADDR     7'h17

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TMR_CARRY_SEL_LSB        0
`define TMR_IRQ_SEL_LSB          2
`define TMR_CARRY_FLAG_BIT       0
`define TMR_INTERVAL_SELECT_RST  4'h0

// ----------------------------------------------------------------
// timing: tick periods in microseconds, clock period in ns
// ----------------------------------------------------------------
`define TMR_CLK_PERIOD_NS        40
`define TMR_TICK_1KHZ_US         1000
`define TMR_TICK_200HZ_US        5000
`define TMR_TICK_10HZ_US         100000
`define TMR_TICK_4HZ_US          250000

`endif

// ==== src/interval_timer_pkg.sv ====
// types shared by the interval timer modules
package interval_timer_pkg;

  typedef enum logic [1:0] {
    CE_IDLE,
    CE_WAIT_TICK
  } ce_state_t;

  typedef struct packed {
    logic [3:0][27:0] cnt;
    logic [3:0]       lvl;
  } div_state_t;

  typedef struct packed {
    logic       flag;
    logic       armed;
    logic [3:0] mode;
    logic [3:0] rdata;
    logic       carry_lvl_prev;
    logic       irq_lvl_prev;
    logic       ce_prev;
    ce_state_t  ce_state;
    logic       irq;
    logic       ce_rst;
  } carry_state_t;

endpackage

// ==== src/tick_divider.sv ====
// free-running divider producing four independent square-wave tick pulses
`timescale 1ns/1ps
module tick_divider
  import interval_timer_pkg::*;
#(
  parameter logic [3:0][27:0] PERIODS = '{28'd10, 28'd20, 28'd40, 28'd80}
)
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // tick levels, index 0 fastest
  output logic      [3:0] tick_lvl_out
);

  div_state_t st_ff;
  div_state_t nxt_st;

  // --------------------------------------------------------------
  // counters: low for first half of period, high for second
  // --------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    for (int i = 0; i < 4; i++)
    begin
      if (st_ff.cnt[i] >= PERIODS[i] - 28'd1)
        nxt_st.cnt[i] = '0;
      else
        nxt_st.cnt[i] = st_ff.cnt[i] + 28'd1;
      nxt_st.lvl[i] = (nxt_st.cnt[i] >= (PERIODS[i] >> 1));
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign tick_lvl_out = st_ff.lvl;

endmodule // tick_divider

// ==== dv/cpu_core_model.sv ====
// cpu core model driving the register file port
`timescale 1ns/1ps
module cpu_core_model
(
  // clock
  input  wire logic       ref_clk_in,
  // register file port
  output logic      [6:0] addr_out,
  output logic            rd_op_out,
  output logic            wr_op_out,
  output logic      [3:0] wdata_out,
  input  wire logic [3:0] rdata_in
);
  initial
  begin
    addr_out  = 7'h00;
    rd_op_out = 1'b0;
    wr_op_out = 1'b0;
    wdata_out = 4'h0;
  end

  // idle address and data are inverted so a stale value never looks valid
  task automatic rd(input logic [6:0] a, output logic [3:0] d);
    @(posedge ref_clk_in);
    #1;
    addr_out  = a;
    rd_op_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    rd_op_out = 1'b0;
    addr_out  = ~a;
    @(posedge ref_clk_in);
    #1;
    d = rdata_in;
  endtask

  task automatic wr(input logic [6:0] a, input logic [3:0] v);
    @(posedge ref_clk_in);
    #1;
    addr_out  = a;
    wdata_out = v;
    wr_op_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    wr_op_out = 1'b0;
    addr_out  = ~a;
    wdata_out = ~v;
  endtask
endmodule // cpu_core_model

// ==== dv/interval_timer_carry_tb.sv ====
// self-checking bench for the interval timer carry block
`timescale 1ns/1ps
module interval_timer_carry_tb;
  logic       ref_clk_in;
  logic       rst_in;
  logic       ce_in;
  logic       clk_stop_in;
  logic [6:0] addr;
  logic       rd_op;
  logic       wr_op;
  logic [3:0] wdata;
  logic [3:0] rd_data_out;
  logic       tick_carry_flag_out;
  logic       timer_irq_out;
  logic       ce_reset_out;
  logic [3:0] d;
  int         n;
  int         err_count;
  int         compares;
  int         cycles;

  // short tick periods keep the run small
  interval_timer_carry #(.TICK_1KHZ_CYC(8), .TICK_200HZ_CYC(16), .TICK_10HZ_CYC(40),
    .TICK_4HZ_CYC(64)) u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .register_file_space_addr_in(addr), .register_file_read_op_in(rd_op),
    .register_file_write_op_in(wr_op), .wr_data_in(wdata), .rd_data_out(rd_data_out),
    .ce_in(ce_in), .clk_stop_in(clk_stop_in), .tick_carry_flag_out(tick_carry_flag_out),
    .timer_irq_out(timer_irq_out), .ce_reset_out(ce_reset_out));

  cpu_core_model u_cpu (.ref_clk_in(ref_clk_in), .addr_out(addr), .rd_op_out(rd_op),
    .wr_op_out(wr_op), .wdata_out(wdata), .rdata_in(rd_data_out));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bounded wait: 0 flag, 1 irq, 2 ce reset
  task automatic wait_hi(input int sel, output int c);
    c = 0;
    do
    begin
      @(posedge ref_clk_in);
      #1;
      c++;
    end
    while (!(sel == 0 ? tick_carry_flag_out === 1'b1 : sel == 1 ? timer_irq_out === 1'b1
             : ce_reset_out === 1'b1) && c < 100);
    if (c >= 100)
    begin
      err_count++;
      $display("[FAIL] wait_hi %0d expected event seen timeout", sel);
    end
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_por;
    u_cpu.rd(7'h09, d);
    chk("mode reset", 8'h00, {4'h0, d});
    u_cpu.wr(7'h09, 4'h3);
    u_cpu.rd(7'h09, d);
    chk("mode readback", 8'h03, {4'h0, d});
    repeat (30) @(posedge ref_clk_in);
    #1;
    chk("flag blocked", 8'h00, {7'h00, tick_carry_flag_out});
    u_cpu.rd(7'h17, d);
    chk("first judge", 8'h00, {4'h0, d});
  endtask

  task automatic t_carry;
    wait_hi(0, n);
    chk("flag set", 8'h01, {7'h00, tick_carry_flag_out});
    u_cpu.rd(7'h17, d);
    chk("judge", 8'h01, {4'h0, d});
    chk("flag cleared", 8'h00, {7'h00, tick_carry_flag_out});
    wait_hi(0, n);
    chk("carry period", 8'd5, n[7:0]);
  endtask

  task automatic t_ro;
    u_cpu.wr(7'h17, 4'h0);
    chk("flag after write", 8'h01, {7'h00, tick_carry_flag_out});
    u_cpu.rd(7'h7f, d);
    chk("unmapped", 8'h00, {4'h0, d});
  endtask

  task automatic t_irq;
    u_cpu.wr(7'h09, 4'h8);
    repeat (2) wait_hi(1, n);
    wait_hi(1, n);
    chk("irq interval", 8'd16, n[7:0]);
  endtask

  // carry 250 ms and irq 1 ms; the carry count is the period less the 3-cycle read
  task automatic t_sel;
    u_cpu.wr(7'h09, 4'hd);
    repeat (2) wait_hi(1, n);
    wait_hi(1, n);
    chk("irq 1 ms interval", 8'd8, n[7:0]);
    u_cpu.rd(7'h17, d);
    wait_hi(0, n);
    u_cpu.rd(7'h17, d);
    wait_hi(0, n);
    u_cpu.rd(7'h17, d);
    wait_hi(0, n);
    chk("carry 250 ms period", 8'd61, n[7:0]);
  endtask

  task automatic t_reset;
    ce_in       = 1'b0;
    clk_stop_in = 1'b0;
    rst_in      = 1'b1;
    repeat (10) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    chk("reset flag", 8'h00, {7'h00, tick_carry_flag_out});
    chk("reset rdata", 8'h00, {4'h0, rd_data_out});
    chk("reset events", 8'h00, {6'h00, timer_irq_out, ce_reset_out});
    u_cpu.rd(7'h09, d);
    chk("mode after reset", 8'h00, {4'h0, d});
    repeat (45) @(posedge ref_clk_in);
    #1;
    chk("flag blocked again", 8'h00, {7'h00, tick_carry_flag_out});
  endtask

  task automatic t_ce;
    u_cpu.wr(7'h09, 4'h3);
    u_cpu.rd(7'h17, d);
    ce_in = 1'b1;
    wait_hi(2, n);
    chk("ce sync", 8'h01, {7'h00, n <= 9});
    chk("ce flag", 8'h01, {7'h00, tick_carry_flag_out});
    ce_in = 1'b0;
    // re-arm ce reset, then read 17H on the edge of the next carry tick
    @(posedge ref_clk_in);
    #1;
    ce_in = 1'b1;
    repeat (5) @(posedge ref_clk_in);
    u_cpu.rd(7'h17, d);
    chk("read vs tick", 8'h01, {7'h00, tick_carry_flag_out});
    wait_hi(2, n);
    chk("ce delayed", 8'd7, n[7:0]);
    ce_in = 1'b0;
    clk_stop_in = 1'b1;
    u_cpu.rd(7'h17, d);
    chk("stop clear", 8'h00, {7'h00, tick_carry_flag_out});
    ce_in = 1'b1;
    wait_hi(2, n);
    chk("stop ce", 8'h01, {7'h00, n <= 2});
    chk("stop flag", 8'h01, {7'h00, tick_carry_flag_out});
  endtask

  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst_in      = 1'b1;
    ce_in       = 1'b0;
    clk_stop_in = 1'b0;
    err_count   = 0;
    compares    = 0;
    cycles      = 0;
    repeat (10) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    t_por();
    t_carry();
    t_ro();
    t_irq();
    t_sel();
    t_ce();
    t_reset();
    tally_and_finish();
  end
endmodule // interval_timer_carry_tb
